// ---- shared/char_format_pkg.sv ----
// Register map, field layout and timing constants for the character format block.
package char_format_pkg;
  localparam logic [7:0] ADDR_CHAR_FORMAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h11;
  localparam logic [7:0] ADDR_TX_DATA     = 8'h12;
  localparam logic [7:0] ADDR_RX_DATA     = 8'h13;
  localparam logic [7:0] ADDR_LINE_STATUS = 8'h14;
  localparam logic [7:0] CHAR_FORMAT_RESET = 8'h00;
  localparam int PARITY_TYPE_BIT = 7;
  localparam int PARITY_MODE_HI  = 6;
  localparam int PARITY_MODE_LO  = 5;
  localparam int IGNORE_BIT      = 4;
  localparam int STOP_LEN_HI     = 3;
  localparam int STOP_LEN_LO     = 2;
  localparam int CHAR_LEN_HI     = 1;
  localparam int CHAR_LEN_LO     = 0;
  localparam logic [1:0] PAR_NONE   = 2'h0;
  localparam logic [1:0] PAR_FORCE  = 2'h1;
  localparam logic [1:0] PAR_NORMAL = 2'h2;
  // Status bit positions.
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_PARITY  = 1;
  localparam int IRQ_FRAME   = 2;
  localparam int IRQ_TX_DONE = 3;
  // Bit timing: 16 clocks of 100 ns per bit at 10 MHz.
  localparam int CLK_HZ     = 10_000_000;
  localparam int BIT_NS     = 1600;
  localparam int BIT_CYCLES = (BIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int HALF_CYCLES = BIT_CYCLES / 2;
  localparam logic [5:0] BIT_CNT_MAX = 6'(BIT_CYCLES - 1);
  localparam logic [5:0] HALF_CNT    = 6'(HALF_CYCLES - 1);
  localparam logic [3:0] DATA_BITS_MIN = 4'h5;

  // Number of data bits selected by a character length code.
  function automatic logic [3:0] data_bits(input logic [1:0] code);
    data_bits = DATA_BITS_MIN + {2'h0, code};
  endfunction

  // Parity bit value for a character under the given mode and type.
  function automatic logic parity_of(input logic [7:0] data, input logic [1:0] len,
                                     input logic [1:0] mode, input logic odd);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - len);
    if (mode == PAR_FORCE)
      parity_of = odd;
    else
      parity_of = (^(data & m)) ^ odd;
  endfunction

  // Stop half-bit periods: 00 one bit, 01 one and a half, 10 and 11 two.
  function automatic logic [1:0] stop_halves(input logic [1:0] code);
    case (code)
      2'h0:    stop_halves = 2'h2;
      2'h1:    stop_halves = 2'h3;
      default: stop_halves = 2'h0;
    endcase
  endfunction
endpackage

// ---- design/char_rx.sv ----
// Receiver that samples one character with the configured format.
module char_rx
  import char_format_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Format
  input  wire logic [7:0] fmt_i,
  // Line, already synchronised
  input  wire logic       rxd_i,
  // Results
  output logic [7:0]      data_o,
  output logic            done_o,
  output logic            parity_err_o,
  output logic            frame_err_o
);
  typedef enum logic [1:0] {
    RX_IDLE   = 2'b00,
    RX_START  = 2'b01,
    RX_DATA   = 2'b10,
    RX_STOP   = 2'b11
  } rx_state_t;

  typedef struct packed {
    rx_state_t  st;
    logic [5:0] cnt;
    logic [3:0] idx;
    logic [7:0] shift;
    logic       par;
    logic       par_phase;
    logic [7:0] data;
    logic       done;
    logic       perr;
    logic       ferr;
  } rx_t;

  rx_t r;
  rx_t next_r;
  logic [1:0] mode;

  assign mode = fmt_i[PARITY_MODE_HI:PARITY_MODE_LO];

  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.perr = 1'b0;
    next_r.ferr = 1'b0;
    unique case (r.st)
      RX_IDLE:
      begin
        if (!rxd_i)
        begin
          next_r.st = RX_START;
          next_r.cnt = HALF_CNT;
        end
      end
      RX_START:
      begin
        if (r.cnt != 6'h00)
          next_r.cnt = r.cnt - 6'h01;
        else if (rxd_i)
          next_r.st = RX_IDLE;
        else
        begin
          next_r.st = RX_DATA;
          next_r.cnt = BIT_CNT_MAX;
          next_r.idx = 4'h0;
          next_r.shift = 8'h00;
          next_r.par_phase = 1'b0;
        end
      end
      RX_DATA:
      begin
        if (r.cnt != 6'h00)
          next_r.cnt = r.cnt - 6'h01;
        else
        begin
          next_r.cnt = BIT_CNT_MAX;
          if (r.par_phase)
          begin
            next_r.par = rxd_i;
            next_r.st = RX_STOP;
          end
          else
          begin
            next_r.shift = r.shift | ({7'h00, rxd_i} << r.idx[2:0]);
            next_r.idx = r.idx + 4'h1;
            if (r.idx + 4'h1 == data_bits(fmt_i[CHAR_LEN_HI:CHAR_LEN_LO]))
            begin
              if (mode == PAR_FORCE || mode == PAR_NORMAL)
                next_r.par_phase = 1'b1;
              else
                next_r.st = RX_STOP;
            end
          end
        end
      end
      RX_STOP:
      begin
        if (r.cnt != 6'h00)
          next_r.cnt = r.cnt - 6'h01;
        else
        begin
          next_r.st = RX_IDLE;
          next_r.data = r.shift;
          next_r.done = 1'b1;
          next_r.ferr = !rxd_i;
          // Parity is checked only when enabled and not ignored.
          if ((mode == PAR_FORCE || mode == PAR_NORMAL) && !fmt_i[IGNORE_BIT])
            next_r.perr = r.par != parity_of(r.shift, fmt_i[CHAR_LEN_HI:CHAR_LEN_LO],
                                              mode, fmt_i[PARITY_TYPE_BIT]);
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      r <= '{st: RX_IDLE, default: '0};
    else
      r <= next_r;
  end

  assign data_o = r.data;
  assign done_o = r.done;
  assign parity_err_o = r.perr;
  assign frame_err_o = r.ferr;
endmodule

// ---- design/serial_char_format_config.sv ----
// Character format register, transmitter framing and interrupt logic of one serial channel.
//
// Implementation choice: the plain strobed port.
module serial_char_format_config
  import char_format_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  // Serial line
  input  wire logic       rxd_i,
  output logic            txd_o,
  // Interrupt
  output logic            irq_o
);
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } tx_state_t;

  typedef struct packed {
    logic [7:0] fmt;
    logic [3:0] status;
    logic [3:0] mask;
    logic [7:0] rdata;
    logic [7:0] rx_hold;
    logic [2:0] sync;
    logic       rxd;
    tx_state_t  st;
    logic [5:0] cnt;
    logic [3:0] idx;
    logic [7:0] shift;
    logic       par_phase;
    logic       par;
    logic [1:0] halves;
    logic       txd;
  } top_t;

  top_t s;
  top_t next_s;
  logic [7:0] rx_data;
  logic       rx_done;
  logic       rx_perr;
  logic       rx_ferr;
  logic [1:0] mode;
  logic [3:0] events;

  assign mode = s.fmt[PARITY_MODE_HI:PARITY_MODE_LO];

  char_rx u_rx (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .fmt_i        (s.fmt),
    .rxd_i        (s.rxd),
    .data_o       (rx_data),
    .done_o       (rx_done),
    .parity_err_o (rx_perr),
    .frame_err_o  (rx_ferr)
  );

  always_comb
  begin
    next_s = s;
    events = 4'h0;
    next_s.rdata = 8'h00;

    // Pin input passes three flops; the level changes once the last two agree.
    next_s.sync = {s.sync[1:0], rxd_i};
    if (s.sync[2] == s.sync[1])
      next_s.rxd = s.sync[2];

    if (rx_done)
      next_s.rx_hold = rx_data;

    // Register reads; the status read clears the bits it returned.
    if (rd_i)
    begin
      unique case (addr_i)
        ADDR_CHAR_FORMAT: next_s.rdata = s.fmt;
        ADDR_IRQ_STATUS:
        begin
          next_s.rdata = {4'h0, s.status};
          next_s.status = 4'h0;
        end
        ADDR_IRQ_MASK:    next_s.rdata = {4'h0, s.mask};
        ADDR_RX_DATA:     next_s.rdata = s.rx_hold;
        ADDR_LINE_STATUS: next_s.rdata = {6'h00, s.rxd, s.st == TX_IDLE};
        default:          next_s.rdata = 8'h00;
      endcase
    end

    if (wr_i)
    begin
      unique case (addr_i)
        ADDR_CHAR_FORMAT: next_s.fmt = wdata_i;
        ADDR_IRQ_MASK:    next_s.mask = wdata_i[3:0];
        default:          next_s.mask = s.mask;
      endcase
    end

    // Transmitter; a write while busy is dropped, software polls the idle bit.
    unique case (s.st)
      TX_IDLE:
      begin
        next_s.txd = 1'b1;
        if (wr_i && addr_i == ADDR_TX_DATA)
        begin
          next_s.shift = wdata_i;
          next_s.st = TX_START;
          next_s.cnt = BIT_CNT_MAX;
          next_s.txd = 1'b0;
          next_s.idx = 4'h0;
          next_s.par_phase = 1'b0;
          next_s.par = parity_of(wdata_i, s.fmt[CHAR_LEN_HI:CHAR_LEN_LO],
                                 mode, s.fmt[PARITY_TYPE_BIT]);
        end
      end
      TX_START, TX_DATA:
      begin
        if (s.cnt != 6'h00)
          next_s.cnt = s.cnt - 6'h01;
        else
        begin
          next_s.cnt = BIT_CNT_MAX;
          next_s.st = TX_DATA;
          if (s.par_phase || s.idx == data_bits(s.fmt[CHAR_LEN_HI:CHAR_LEN_LO]))
          begin
            if (!s.par_phase && (mode == PAR_FORCE || mode == PAR_NORMAL))
            begin
              next_s.par_phase = 1'b1;
              next_s.txd = s.par;
            end
            else
            begin
              next_s.st = TX_STOP;
              next_s.txd = 1'b1;
              next_s.cnt = HALF_CNT;
              next_s.halves = stop_halves(s.fmt[STOP_LEN_HI:STOP_LEN_LO]) - 2'h1;
            end
          end
          else
          begin
            next_s.txd = s.shift[s.idx[2:0]];
            next_s.idx = s.idx + 4'h1;
          end
        end
      end
      TX_STOP:
      begin
        next_s.txd = 1'b1;
        if (s.cnt != 6'h00)
          next_s.cnt = s.cnt - 6'h01;
        else if (s.halves != 2'h0)
        begin
          // Stop time runs in half-bit steps so one and a half bits fits.
          next_s.halves = s.halves - 2'h1;
          next_s.cnt = HALF_CNT;
        end
        else
        begin
          next_s.st = TX_IDLE;
          events[IRQ_TX_DONE] = 1'b1;
        end
      end
    endcase

    events[IRQ_RX_DONE] = rx_done;
    events[IRQ_PARITY]  = rx_perr;
    events[IRQ_FRAME]   = rx_ferr;
    // Setting wins over a clear by read in the same cycle.
    next_s.status = next_s.status | events;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      s <= '{fmt: CHAR_FORMAT_RESET, st: TX_IDLE, sync: 3'h7, rxd: 1'b1, txd: 1'b1,
             default: '0};
    else
      s <= next_s;
  end

  assign rdata_o = s.rdata;
  assign txd_o = s.txd;
  assign irq_o = |(s.status & s.mask);
endmodule

// ---- sim/serial_char_format_config_props.sv ----
// Checker of format readback and transmit framing, seen from the pins.
module serial_char_format_config_props
  import char_format_pkg::*;
(
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  // Line and interrupt
  input wire logic       rxd_i,
  input wire logic       txd_o,
  input wire logic       irq_o
);
  logic [7:0] f;
  logic [7:0] td;
  logic       tq;
  logic       busy;
  int         cnt;
  int         psl;
  int         ss;
  logic       pe;
  assign pe  = (f[6:5] == PAR_FORCE) || (f[6:5] == PAR_NORMAL);
  assign psl = 16 * (6 + int'(f[1:0]));
  assign ss  = pe ? psl + 16 : psl;
  // Shadows of format and character let a frame be judged without seeing inside.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      f <= 8'h00;
      td <= 8'h00;
      tq <= 1'b1;
      busy <= 1'b0;
      cnt <= 0;
    end
    else
    begin
      tq <= txd_o;
      if (wr_i && addr_i == ADDR_CHAR_FORMAT)
        f <= wdata_i;
      if (wr_i && addr_i == ADDR_TX_DATA && !busy)
        td <= wdata_i;
      if (!busy && tq && !txd_o)
      begin
        busy <= 1'b1;
        cnt <= 1;
      end
      else if (busy)
      begin
        cnt <= cnt + 1;
        if (cnt == ss + 16)
          busy <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_fmt_read: assert property (rd_i && addr_i == ADDR_CHAR_FORMAT |=> rdata_o == $past(f))
    else $error("format readback wrong");
  a_lsb_first: assert property (busy && cnt == 24 |-> txd_o == td[0])
    else $error("first data bit wrong");
  a_char_len: assert property (busy && cnt == psl - 8 |-> txd_o == td[f[1:0] + 4])
    else $error("last data bit wrong");
  a_force_par: assert property (busy && cnt == psl + 8 && f[6:5] == PAR_FORCE |-> txd_o == f[7])
    else $error("forced parity bit wrong");
  a_normal_par: assert property (busy && cnt == psl + 8 && f[6:5] == PAR_NORMAL
    |-> txd_o == ((^(td & (8'hFF >> (3 - f[1:0])))) ^ f[7]))
    else $error("parity bit wrong");
  a_no_par: assert property (busy && cnt == psl + 8 && !pe |-> txd_o)
    else $error("parity slot not stop");
  a_stop_high: assert property (busy && cnt == ss + 1 |-> txd_o [*8])
    else $error("stop bit low");
  a_stop_end: assert property (busy && cnt == ss + 15 |-> txd_o)
    else $error("stop bit cut short");
endmodule

bind serial_char_format_config serial_char_format_config_props i_props (.clk_i(clk_i),
  .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o), .irq_o(irq_o));

// ---- sim/remote_line.sv ----
// Remote serial equipment: sends and samples frames at 16 clocks a bit.
module remote_line
(
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd_o = 1'b1;
  // Bits go LSB first after the start bit; the line returns to mark after.
  task automatic send(input logic [11:0] b, input int nb);
    @(posedge clk_i);
    rxd_o <= 1'b0;
    repeat (16) @(posedge clk_i);
    for (int i = 0; i < nb; i++)
    begin
      rxd_o <= b[i];
      repeat (16) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask
  // Samples near mid-bit so a clock or two of skew does not matter.
  task automatic cap(output logic [11:0] b, input int nb);
    int w;
    w = 0;
    b = 12'h000;
    while (txd_i !== 1'b0 && w < 2000)
    begin
      @(posedge clk_i);
      w++;
    end
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < nb; i++)
    begin
      repeat (16) @(posedge clk_i);
      b[i] = txd_i;
    end
  endtask
endmodule

// ---- sim/serial_char_format_config_tb.sv ----
// Testbench for the character format block over registers and line.
module serial_char_format_config_tb
  import char_format_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       rxd;
  logic       txd;
  logic       irq;
  int         bad_count = 0;
  int         checks_done = 0;
  logic [7:0] txf [6] = '{8'h00, 8'hA5, 8'h2A, 8'hCF, 8'h42, 8'h71};
  logic [7:0] rxf [6] = '{8'h43, 8'h43, 8'h53, 8'hA0, 8'h01, 8'h60};
  logic [7:0] rxv [6] = '{8'hA5, 8'hA5, 8'hA5, 8'h1F, 8'hFF, 8'h0A};
  logic [7:0] rxs [6] = '{8'h01, 8'h03, 8'h01, 8'h03, 8'h01, 8'h01};
  logic [5:0] flip = 6'h0E;
  initial forever #50 clk = ~clk;
  serial_char_format_config i_dut (.clk_i(clk), .rst_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rxd_i(rxd),
    .txd_o(txd), .irq_o(irq));
  remote_line i_far (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // Line image of a character: data, optional parity (fl inverts it), one stop.
  function automatic logic [11:0] frame(input logic [7:0] f, input logic [7:0] d,
                                        input logic fl, output int nb);
    logic [11:0] b;
    b = 12'h000;
    nb = 5 + int'(f[1:0]);
    for (int i = 0; i < nb; i++)
      b[i] = d[i];
    if (f[6:5] == 2'h1)
      b[nb++] = f[7] ^ fl;
    else if (f[6:5] == 2'h2)
      b[nb++] = (^b[7:0]) ^ f[7] ^ fl;
    b[nb++] = 1'b1;
    return b;
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    logic [7:0] v;
    logic [11:0] b;
    logic [11:0] e;
    int nb;
    int w;
    int s;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rreg(ADDR_CHAR_FORMAT, v);
    chk("format reset", CHAR_FORMAT_RESET, v);
    rreg(8'h00, v);
    chk("unmapped", 8'h00, v);
    wreg(ADDR_IRQ_MASK, 8'h08);
    for (int i = 0; i < 6; i++)
    begin
      wreg(ADDR_CHAR_FORMAT, txf[i]);
      rreg(ADDR_CHAR_FORMAT, v);
      chk("format", txf[i], v);
      e = frame(txf[i], 8'h96 ^ 8'(i), 1'b0, nb);
      wreg(ADDR_TX_DATA, 8'h96 ^ 8'(i));
      i_far.cap(b, nb);
      chk("tx low", e[7:0], b[7:0]);
      chk("tx high", {4'h0, e[11:8]}, {4'h0, b[11:8]});
      s = (txf[i][3:2] == 2'h0) ? 16 : (txf[i][3:2] == 2'h1) ? 24 : 32;
      w = 0;
      while (irq !== 1'b1 && w < 40)
      begin
        @(negedge clk);
        w++;
      end
      chk("stop length", 8'h01, {7'h00, (w >= s - 12 && w <= s - 6)});
      rreg(ADDR_IRQ_STATUS, v);
      chk("tx status", 8'h08, v);
      chk("irq cleared", 8'h00, {7'h00, irq});
    end
    wreg(ADDR_IRQ_MASK, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wreg(ADDR_CHAR_FORMAT, rxf[i]);
      e = frame(rxf[i], rxv[i], flip[i], nb);
      i_far.send(e, nb);
      repeat (12) @(posedge clk);
      chk("irq masked", 8'h00, {7'h00, irq});
      rreg(ADDR_IRQ_STATUS, v);
      chk("rx status", rxs[i], v);
      rreg(ADDR_RX_DATA, v);
      chk("rx data", rxv[i] & (8'hFF >> (2'h3 - rxf[i][1:0])), v);
    end
    results();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule
